// File: logic/mg_pkg.sv
// shared constants, types and helpers for the modem storage and upstream guard
package mg_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int NVM_AW  = 8;
   localparam int NVM_DW  = 8;
   localparam int NPARAM  = 8;
   localparam int PARAM_W = 16;
   localparam int CHAN_W  = 8;

   // ------------------------------------------------------------
   // storage map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] CM_MAC_LO   = 8'h00;
   localparam logic [7:0] CM_MAC_HI   = 8'h05;
   localparam logic [7:0] HOST_MAC_LO = 8'h06;
   localparam logic [7:0] HOST_MAC_HI = 8'h0b;
   localparam logic [7:0] SIZE_LO     = 8'h0c;
   localparam logic [7:0] SIZE_HI     = 8'h0d;
   localparam logic [7:0] CRC_LO      = 8'h0e;
   localparam logic [7:0] CRC_HI      = 8'h0f;
   localparam logic [7:0] CERT_LO     = 8'h10;
   localparam logic [7:0] CERT_HI     = 8'h9f;
   localparam logic [7:0] KEY_LO      = 8'ha0;
   localparam logic [7:0] KEY_HI      = 8'hdf;
   localparam logic [7:0] OPT_LO      = 8'he0;
   localparam logic [8:0] NVM_DEPTH   = 9'h100;

   // ------------------------------------------------------------
   // reset values and checksum constants
   // ------------------------------------------------------------
   localparam logic [15:0] CRC_INIT   = 16'hffff;
   localparam logic [15:0] CRC_POLY   = 16'h1021;
   localparam logic [15:0] TEST_RST   = 16'h0000;
   localparam logic [15:0] PARAM_RST  = 16'h0000;
   localparam logic [7:0]  CHAN_RST   = 8'h00;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {SEL_NVM, SEL_PARAM, SEL_TEST, SEL_NONE} mg_sel_t;
   typedef enum logic [1:0] {ST_IDLE, ST_META, ST_WALK, ST_CHECK} mg_diag_t;

   // identity objects: modem address, certificate, private key
   function automatic logic mg_protected(input logic [7:0] a);
      mg_protected = (a <= CM_MAC_HI) || (a >= CERT_LO && a <= KEY_HI);
   endfunction

   // one byte of crc-ccitt, msb first
   function automatic logic [15:0] mg_crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         if (r[15] ^ d[i]) begin
            r = {r[14:0], 1'b0} ^ CRC_POLY;
         end else begin
            r = {r[14:0], 1'b0};
         end
      end
      mg_crc_byte = r;
   endfunction

endpackage

// File: logic/mg_mem_if.sv
// storage port between the guard and its storage array
`timescale 1ns/1ps
interface mg_mem_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       we;
   logic [7:0] rdata;

   modport ctrl (output addr, output wdata, output we, input rdata);
   modport mem  (input addr, input wdata, input we, output rdata);
endinterface

// File: logic/mg_nvm_mem.sv
// storage array, 256 bytes, registered read
`timescale 1ns/1ps
module mg_nvm_mem
   import mg_pkg::*;
(
   // clock
   input  wire logic i_clk_sys,
   // storage port
   mg_mem_if.mem     mem
);
   // array is not reset: it models contents that survive power cycles
   logic [NVM_DW-1:0] arr [0:255];
   logic [NVM_DW-1:0] rd;

   always_ff @(posedge i_clk_sys) begin
      if (mem.we) begin
         arr[mem.addr] <= mem.wdata;
      end
      rd <= arr[mem.addr];
   end

   assign mem.rdata = rd;
endmodule

// File: logic/mg_guard.sv
// storage write guard, checksum diagnostic and upstream parameter lock
`timescale 1ns/1ps
// Function
// - storage holds modem address, certificate and private key at fixed locations
// - host writes aimed at identity objects never reach the array without factory enable
// - identity writes only possible with factory enable; none in the field
// - storage holds the host computer address, writable by host
// - storage holds a size field giving used space
// - diagnostic recomputes crc-ccitt over used space and compares stored value
// - spare locations may hold extra addresses, descriptors, parameters
// - upstream disable message turns transmitter off in hardware
// - upstream parameters updated only from headend messages
// - host can never write upstream parameters
// - host cannot write test registers without factory enable
// - host channel change to unknown channel id forces reinitialisation
module mg_guard
   import mg_pkg::*;
(
   // clock and reset
   input  wire logic                      i_clk_sys,
   input  wire logic                      i_sys_rst,
   // factory pin
   input  wire logic                      i_factory_en,
   // host access port
   input  wire logic                      i_host_wr,
   input  wire logic                      i_host_rd,
   input  wire logic [1:0]                i_host_sel,
   input  wire logic [7:0]                i_host_addr,
   input  wire logic [15:0]               i_host_wdata,
   output logic      [15:0]               o_host_rdata,
   output logic                           o_host_rvalid,
   output logic                           o_busy,
   // diagnostic
   input  wire logic                      i_diag_start,
   output logic                           o_diag_done,
   output logic                           o_crc_ok,
   output logic                           o_crc_err,
   // headend messages
   input  wire logic                      i_hd_wr,
   input  wire logic [2:0]                i_hd_idx,
   input  wire logic [15:0]               i_hd_data,
   input  wire logic                      i_ucd_rx,
   input  wire logic [7:0]                i_ucd_chan,
   input  wire logic                      i_updis_rx,
   input  wire logic                      i_upen_rx,
   // host channel change
   input  wire logic                      i_ucc_wr,
   input  wire logic [7:0]                i_ucc_chan,
   // upstream control
   output logic [NPARAM*PARAM_W-1:0]      o_us_params,
   output logic [15:0]                    o_test_ctrl,
   output logic                           o_us_tx_en,
   output logic [7:0]                     o_us_chan,
   output logic                           o_reinit
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic                            fac0;
      logic                            fac1;
      mg_diag_t                        st;
      logic [8:0]                      cnt;
      logic                            dv;
      logic                            dmeta;
      logic [7:0]                      daddr;
      logic [15:0]                     size;
      logic [15:0]                     crc_st;
      logic [15:0]                     crc;
      logic                            hpend;
      logic                            hnvm;
      logic [15:0]                     hold;
      logic [15:0]                     rdata;
      logic                            rvalid;
      logic                            busy;
      logic                            done;
      logic                            ok;
      logic                            err;
      logic [NPARAM-1:0][PARAM_W-1:0]  params;
      logic [15:0]                     test;
      logic                            tx_en;
      logic [7:0]                      chan;
      logic [255:0]                    seen;
      logic                            reinit;
   } mg_state_t;

   mg_state_t s;
   mg_state_t next_s;

   mg_mem_if mif ();

   mg_nvm_mem u_mem (
      .i_clk_sys (i_clk_sys),
      .mem       (mif.mem)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic       mem_we;
   logic [7:0] mem_addr;
   logic       walk_more;
   logic       host_go;

   always_comb begin
      next_s    = s;
      mem_we    = 1'b0;
      mem_addr  = i_host_addr;
      walk_more = (s.cnt[8] == 1'b0) && ({7'h00, s.cnt} < s.size);
      host_go   = (s.st == ST_IDLE) && !i_diag_start;

      // factory pin synchroniser; only the second stage is used
      next_s.fac0 = i_factory_en;
      next_s.fac1 = s.fac0;

      // host read data, one cycle after the array answers
      next_s.rvalid = s.hpend;
      next_s.hpend  = 1'b0;
      if (s.hpend) begin
         next_s.rdata = s.hnvm ? {8'h00, mif.rdata} : s.hold;
      end

      // host access, only while the diagnostic is idle
      if (host_go && i_host_rd) begin
         next_s.hpend = 1'b1;
         next_s.hnvm  = (mg_sel_t'(i_host_sel) == SEL_NVM);
         case (mg_sel_t'(i_host_sel))
            SEL_PARAM: next_s.hold = s.params[i_host_addr[2:0]];
            SEL_TEST:  next_s.hold = s.test;
            default:   next_s.hold = 16'h0000;
         endcase
      end else if (host_go && i_host_wr) begin
         case (mg_sel_t'(i_host_sel))
            SEL_NVM: begin
               // identity objects need the synchronised factory pin
               mem_we = !mg_protected(i_host_addr) || s.fac1;
            end
            SEL_TEST: begin
               if (s.fac1) begin
                  next_s.test = i_host_wdata;
               end
            end
            default: begin
               // parameter writes from the host are dropped silently
               next_s.test = next_s.test;
            end
         endcase
      end

      // checksum diagnostic: absorb returning byte
      next_s.dv = 1'b0;
      if (s.dv) begin
         if (s.dmeta) begin
            case (s.daddr)
               SIZE_LO: next_s.size[7:0]    = mif.rdata;
               SIZE_HI: next_s.size[15:8]   = mif.rdata;
               CRC_LO:  next_s.crc_st[7:0]  = mif.rdata;
               default: next_s.crc_st[15:8] = mif.rdata;
            endcase
         end else if (s.daddr != CRC_LO && s.daddr != CRC_HI) begin
            // the stored checksum cannot cover itself, so it is skipped
            next_s.crc = mg_crc_byte(s.crc, mif.rdata);
         end
      end

      case (s.st)
         ST_IDLE: begin
            if (i_diag_start) begin
               next_s.st   = ST_META;
               next_s.cnt  = 9'h000;
               next_s.crc  = CRC_INIT;
               next_s.done = 1'b0;
               next_s.ok   = 1'b0;
               next_s.err  = 1'b0;
            end
         end
         ST_META: begin
            mem_addr     = SIZE_LO + s.cnt[7:0];
            next_s.dv    = 1'b1;
            next_s.dmeta = 1'b1;
            next_s.daddr = mem_addr;
            next_s.cnt   = s.cnt + 9'h001;
            if (s.cnt == 9'h003) begin
               next_s.st  = ST_WALK;
               next_s.cnt = 9'h000;
            end
         end
         ST_WALK: begin
            if (walk_more) begin
               mem_addr     = s.cnt[7:0];
               next_s.dv    = 1'b1;
               next_s.dmeta = 1'b0;
               next_s.daddr = mem_addr;
               next_s.cnt   = s.cnt + 9'h001;
            end else begin
               next_s.st = ST_CHECK;
            end
         end
         default: begin
            if (!s.dv) begin
               next_s.st   = ST_IDLE;
               next_s.done = 1'b1;
               next_s.ok   = (s.crc == s.crc_st);
               next_s.err  = (s.crc != s.crc_st);
            end
         end
      endcase
      next_s.busy = (next_s.st != ST_IDLE);

      // headend owns the upstream parameters
      if (i_hd_wr) begin
         next_s.params[i_hd_idx] = i_hd_data;
      end
      // disable wins over a simultaneous enable
      if (i_updis_rx) begin
         next_s.tx_en = 1'b0;
      end else if (i_upen_rx) begin
         next_s.tx_en = 1'b1;
      end

      // host channel change; channel zero is never accepted, even if announced
      next_s.reinit = 1'b0;
      if (i_ucc_wr) begin
         if (s.seen[i_ucc_chan] && i_ucc_chan != CHAN_RST) begin
            next_s.chan = i_ucc_chan;
         end else begin
            next_s.reinit = 1'b1;
            next_s.chan   = CHAN_RST;
            next_s.seen   = '0;
         end
      end

      // an announcement in the same cycle as a reinit survives the clear
      if (i_ucd_rx) begin
         next_s.seen[i_ucd_chan] = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         s        <= '0;
         s.st     <= ST_IDLE;
         s.crc    <= CRC_INIT;
         s.params <= {NPARAM{PARAM_RST}};
         s.test   <= TEST_RST;
         s.tx_en  <= 1'b1;
         s.chan   <= CHAN_RST;
      end else begin
         s <= next_s;
      end
   end

   assign mif.addr  = mem_addr;
   assign mif.wdata = i_host_wdata[7:0];
   assign mif.we    = mem_we;

   assign o_host_rdata  = s.rdata;
   assign o_host_rvalid = s.rvalid;
   assign o_busy        = s.busy;
   assign o_diag_done   = s.done;
   assign o_crc_ok      = s.ok;
   assign o_crc_err     = s.err;
   assign o_us_params   = s.params;
   assign o_test_ctrl   = s.test;
   assign o_us_tx_en    = s.tx_en;
   assign o_us_chan     = s.chan;
   assign o_reinit      = s.reinit;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   id_write_block_a: assert property (
      i_host_wr && !i_host_rd && !i_diag_start && s.st == ST_IDLE && i_host_sel == 2'b00
      && mg_protected(i_host_addr) && !s.fac1 |-> !mif.we)
      else $error("identity location written without factory enable");

   host_mac_write_a: assert property (
      i_host_wr && !i_host_rd && !i_diag_start && s.st == ST_IDLE && i_host_sel == 2'b00
      && !mg_protected(i_host_addr) |-> mif.we && mif.addr == i_host_addr)
      else $error("host address write not performed");

   factory_sync_a: assert property (
      $rose(s.fac1) |-> $past(i_factory_en, 2))
      else $error("factory enable not synchronised");

   param_lock_a: assert property (
      i_host_wr && !i_hd_wr && !i_sys_rst |=> $stable(o_us_params))
      else $error("host changed upstream parameters");

   test_lock_a: assert property (
      i_host_wr && !s.fac1 |=> $stable(o_test_ctrl))
      else $error("host changed test register");

   updis_off_a: assert property (
      i_updis_rx |=> !o_us_tx_en ##1 (o_us_tx_en == $past(i_upen_rx && !i_updis_rx)
      || !o_us_tx_en))
      else $error("upstream not disabled");

   hd_update_a: assert property (
      i_hd_wr |=> o_us_params[$past(i_hd_idx)*PARAM_W +: PARAM_W] == $past(i_hd_data))
      else $error("headend parameter not taken");

   bad_chan_a: assert property (
      i_ucc_wr && !s.seen[i_ucc_chan] |=> (o_reinit && o_us_chan == CHAN_RST)
      ##1 (!o_reinit || $past(i_ucc_wr)))
      else $error("invalid channel did not reinitialise");

   crc_verdict_a: assert property (
      $rose(o_diag_done) |-> (o_crc_ok == ($past(s.crc) == $past(s.crc_st)))
      && (o_crc_ok != o_crc_err))
      else $error("checksum verdict wrong");

   diag_bound_a: assert property (
      s.st == ST_IDLE && i_diag_start && !i_sys_rst |=> (s.st == ST_META) [*4]
      ##1 (s.st == ST_WALK))
      else $error("diagnostic header phase length wrong");

   cov_diag_ok: cover property ($rose(o_crc_ok));
   cov_id_block: cover property (i_host_wr && mg_protected(i_host_addr) && !s.fac1);
   cov_reinit: cover property (o_reinit);
   cov_updis: cover property ($fell(o_us_tx_en));

endmodule

// File: verif/mg_host_model.sv
// host processor model driving the guard's host access port
`timescale 1ns/1ps
module mg_host_model
   import mg_pkg::*;
(
   // clock
   input  wire logic        i_clk_sys,
   // host access port
   output logic             o_wr,
   output logic             o_rd,
   output logic [1:0]       o_sel,
   output logic [7:0]       o_addr,
   output logic [15:0]      o_wdata,
   input  wire logic [15:0] i_rdata,
   input  wire logic        i_rvalid
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_sel = 2'h3;
      o_addr = 8'h00;
      o_wdata = 16'h0000;
   end

   // released lines flip so a stale value is never mistaken for a live one
   task automatic idle();
      o_sel = ~o_sel;
      o_addr = ~o_addr;
      o_wdata = ~o_wdata;
      @(posedge i_clk_sys);
      #1;
   endtask

   // one-cycle write strobe; called and returns 1 ns after a rising edge
   task automatic wr(input logic [1:0] s, input logic [7:0] a, input logic [15:0] v);
      o_sel = s;
      o_addr = a;
      o_wdata = v;
      o_wr = 1'b1;
      @(posedge i_clk_sys);
      #1;
      o_wr = 1'b0;
      idle();
   endtask

   // read strobe, answer caught within a bounded number of cycles
   task automatic rd(input logic [1:0] s, input logic [7:0] a, output logic [15:0] v);
      bit got;
      got = 1'b0;
      v = 16'hxxxx;
      o_sel = s;
      o_addr = a;
      o_rd = 1'b1;
      @(posedge i_clk_sys);
      #1;
      o_rd = 1'b0;
      repeat (5) begin
         if (!got && i_rvalid === 1'b1) begin
            v = i_rdata;
            got = 1'b1;
         end
         @(posedge i_clk_sys);
         #1;
      end
   endtask
endmodule

// File: verif/testbench.sv
// self-checking testbench for the storage and upstream guard
`timescale 1ns/1ps
module testbench
   import mg_pkg::*;
;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic                       clk = 1'b0;
   logic                       rst, fac, hwr, hrd, busy, dstart, ddone, ok, err;
   logic [1:0]                 hsel;
   logic [7:0]                 haddr, ucdch, uccch, chan;
   logic [15:0]                hwdata, hrdata, hddata, testc, d;
   logic                       hrvalid, hdwr, ucdrx, updis, upen, uccwr, txen, reinit;
   logic [2:0]                 hdidx;
   logic [NPARAM*PARAM_W-1:0]  params;
   logic [7:0]                 img [32];
   logic [7:0]                 la [6] = '{8'h00, 8'h05, 8'h10, 8'h1f, 8'ha0, 8'hdf};
   int                         fails = 0;
   int                         compares = 0;
   int                         reinit_n = 0;

   always #2.5 clk = ~clk;
   always @(posedge clk) if (reinit === 1'b1) reinit_n++;

   mg_host_model u_host (.i_clk_sys(clk), .o_wr(hwr), .o_rd(hrd), .o_sel(hsel),
      .o_addr(haddr), .o_wdata(hwdata), .i_rdata(hrdata), .i_rvalid(hrvalid));

   mg_guard u_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_factory_en(fac),
      .i_host_wr(hwr), .i_host_rd(hrd), .i_host_sel(hsel), .i_host_addr(haddr),
      .i_host_wdata(hwdata), .o_host_rdata(hrdata), .o_host_rvalid(hrvalid),
      .o_busy(busy), .i_diag_start(dstart), .o_diag_done(ddone), .o_crc_ok(ok),
      .o_crc_err(err), .i_hd_wr(hdwr), .i_hd_idx(hdidx), .i_hd_data(hddata),
      .i_ucd_rx(ucdrx), .i_ucd_chan(ucdch), .i_updis_rx(updis), .i_upen_rx(upen),
      .i_ucc_wr(uccwr), .i_ucc_chan(uccch), .o_us_params(params),
      .o_test_ctrl(testc), .o_us_tx_en(txen), .o_us_chan(chan), .o_reinit(reinit));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] exp_at(input logic [7:0] a);
      return (a < 8'h20) ? img[a[4:0]] : 8'hc3;
   endfunction

   // checksum over the used bytes, skipping the two checksum bytes
   function automatic logic [15:0] crc_img();
      logic [15:0] c;
      c = CRC_INIT;
      for (int i = 0; i < 32; i++) begin
         if (i != 14 && i != 15) begin
            for (int b = 7; b >= 0; b--) begin
               c = (c[15] ^ img[i][b]) ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
            end
         end
      end
      return c;
   endfunction

   // start the diagnostic and wait for its verdict
   task automatic diag(input logic exp_ok);
      dstart = 1'b1;
      cyc(1);
      dstart = 1'b0;
      cyc(2);
      chk(busy, 1'b1);
      u_host.wr(2'd0, 8'h06, 16'h0077);
      for (int n = 0; n < 100 && ddone !== 1'b1; n++) cyc(1);
      chk({ddone, busy, ok, err}, {2'b10, exp_ok, ~exp_ok});
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask

   task automatic end_of_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #50000;
      fails++;
      end_of_test();
   end

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {fac, dstart, hdwr, ucdrx, updis, upen, uccwr} = 7'h00;
      {hdidx, hddata, ucdch, uccch} = 35'h0;
      for (int i = 0; i < 32; i++) img[i] = 8'(i * 7 + 3);
      img[12] = 8'h20;
      img[13] = 8'h00;
      {img[15], img[14]} = crc_img();
      cyc(3);
      rst = 1'b0;
      chk({txen, chan, testc, reinit}, {1'b1, 8'h00, 16'h0000, 1'b0});
      chk(32'(params != '0), 32'h0);
      // factory programming through the guarded port
      fac = 1'b1;
      cyc(3);
      for (int i = 0; i < 32; i++) u_host.wr(2'd0, 8'(i), {8'h00, img[i]});
      u_host.wr(2'd0, 8'ha0, 16'h00c3);
      u_host.wr(2'd0, 8'hdf, 16'h00c3);
      u_host.wr(2'd2, 8'h00, 16'h5a5a);
      chk(testc, 16'h5a5a);
      fac = 1'b0;
      cyc(3);
      // field writes to identity bytes and test register are dropped
      foreach (la[k]) begin
         u_host.wr(2'd0, la[k], 16'h003c);
         u_host.rd(2'd0, la[k], d);
         chk(d, {8'h00, exp_at(la[k])});
      end
      u_host.wr(2'd2, 8'h00, 16'h1234);
      chk(testc, 16'h5a5a);
      // parameters follow the headend only
      for (int k = 0; k < 8; k++) begin
         hdidx = 3'(k);
         hddata = 16'h1000 + 16'(k);
         pulse(hdwr);
         u_host.wr(2'd1, 8'(k), 16'hffff);
         chk(params[16*k+:16], 16'h1000 + 16'(k));
      end
      // checksum diagnostic, good then corrupted
      diag(1'b1);
      u_host.rd(2'd0, 8'h06, d);
      chk(d, {8'h00, img[6]});
      u_host.wr(2'd0, 8'h0b, 16'h00e1);
      u_host.rd(2'd0, 8'h0b, d);
      chk(d, 16'h00e1);
      diag(1'b0);
      // upstream disable and re-enable
      pulse(updis);
      chk(txen, 1'b0);
      pulse(upen);
      chk(txen, 1'b1);
      // disable and enable in the same cycle: disable wins
      cyc(1);
      {upen, updis} = 2'b11;
      cyc(1);
      {upen, updis} = 2'b00;
      chk(txen, 1'b0);
      // host channel change: known, unknown, then after the list is cleared
      ucdch = 8'h05;
      pulse(ucdrx);
      uccch = 8'h05;
      pulse(uccwr);
      chk({chan, 8'(reinit_n)}, {8'h05, 8'h00});
      cyc(1);
      uccch = 8'h09;
      pulse(uccwr);
      chk({chan, reinit}, {8'h00, 1'b1});
      cyc(1);
      chk({reinit, 8'(reinit_n)}, {1'b0, 8'h01});
      uccch = 8'h05;
      pulse(uccwr);
      cyc(1);
      chk({chan, 8'(reinit_n)}, {8'h00, 8'h02});
      end_of_test();
   end
endmodule
